// File: rtl/ufs_defines.svh
`ifndef UFS_DEFINES_SVH
`define UFS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define UFS_ADDR_W 8
`define UFS_OFF_TSTAT 8'h0C
`define UFS_OFF_LEVELS 8'h10
`define UFS_OFF_IRQ_STAT 8'h20
`define UFS_OFF_IRQ_MASK 8'h24

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define UFS_BIT_TA_EXP 0
`define UFS_BIT_TB_EXP 1
`define UFS_BIT_TA_GATE 4
`define UFS_BIT_TB_GATE 5
`define UFS_BIT_TA_START 0
`define UFS_BIT_TB_START 1
`define UFS_LVL_RX_LSB 4
`define UFS_LVL_TX_LSB 0
`define UFS_CNT_W 3

// Interrupt status and mask layout.
`define UFS_IRQ_W 4
`define UFS_IRQ_TA 0
`define UFS_IRQ_TB 1
`define UFS_IRQ_RX_FULL 2
`define UFS_IRQ_TX_EMPTY 3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define UFS_RST_GATE 1'b1
`define UFS_RST_EXP 2'h0
`define UFS_RST_IRQ_MASK 4'h0
`define UFS_FIFO_DEPTH 4

`endif

// File: rtl/ufs_pkg.sv
package ufs_pkg;

  // Which register a bus address selects.
  typedef enum logic [2:0] {
    UFS_SEL_NONE = 3'b000,
    UFS_SEL_TSTAT = 3'b001,
    UFS_SEL_LEVELS = 3'b010,
    UFS_SEL_IRQ_STAT = 3'b011,
    UFS_SEL_IRQ_MASK = 3'b100
  } ufs_sel_type;

endpackage

// File: rtl/ufs_status_regs.sv
`include "ufs_defines.svh"

// Summary of operation
// R01: Global timer interrupt bit follows the two timer expired flags.
// R02: Reading the timer status word clears both expired flags, not the gate bits.
// R03: Bits five and four show gate state of timers B and A, no interrupt.
// R04: Timer B terminal-count pulse sets its expired flag, requesting the interrupt.
// R05: Timer A terminal-count pulse sets its expired flag, requesting the interrupt.
// R06: Gate state bits mirror the gate value last written; 1 enables counting.
// R07: Bits six to four report receive FIFO characters, zero to four.
// R08: Bits two to zero report transmit FIFO characters, zero to four.
// R09: Software ignores the timer status word when a timer makes the baud rate.
// R10: Software uses the second instance's own timer interrupts, not polling.
// R11: Software writes reserved bits with their reset value.
// R12: A start command loads the timer; its terminal count sets the flag.
// R13: The gate bit stops counting at 0, allows it at 1, resets enabled.
// R14: Timer interrupt stays while a flag is set; a same-cycle pulse keeps it.
module ufs_status_regs #(
  parameter int FIFO_DEPTH = `UFS_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [`UFS_ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Timer side
  input wire logic timer_a_tc_i,
  input wire logic timer_b_tc_i,
  output logic timer_a_start_o,
  output logic timer_b_start_o,
  output logic timer_a_gate_o,
  output logic timer_b_gate_o,
  // FIFO occupancy from the receive and transmit machines
  input wire logic [`UFS_CNT_W-1:0] rx_fifo_count_i,
  input wire logic [`UFS_CNT_W-1:0] tx_fifo_count_i,
  // Interrupts
  output logic global_timer_irq_o,
  output logic irq_o
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  // The count field is three bits wide, so deeper FIFOs cannot be reported.
  if (FIFO_DEPTH < 1 || FIFO_DEPTH > 7) begin : g_bad_depth
    $error("ufs_status_regs: FIFO_DEPTH must lie in 1..7 to fit the count field");
  end

  localparam logic [`UFS_CNT_W-1:0] DEPTH_C = FIFO_DEPTH[`UFS_CNT_W-1:0];

  // Occupancy beyond the FIFO depth cannot happen; clamp so that a glitch on
  // the count inputs never shows a value outside the documented range.
  function automatic logic [`UFS_CNT_W-1:0] clamp_count(
    input logic [`UFS_CNT_W-1:0] cnt
  );
    clamp_count = (cnt > DEPTH_C) ? DEPTH_C : cnt;
  endfunction

  // Reserved bits of every word read as zero, their reset value.
  function automatic logic [31:0] pack_tstat(
    input logic gate_b,
    input logic gate_a,
    input logic [1:0] expired
  );
    pack_tstat = 32'h00000000;
    pack_tstat[`UFS_BIT_TB_GATE] = gate_b;
    pack_tstat[`UFS_BIT_TA_GATE] = gate_a;
    pack_tstat[`UFS_BIT_TB_EXP] = expired[`UFS_BIT_TB_EXP];
    pack_tstat[`UFS_BIT_TA_EXP] = expired[`UFS_BIT_TA_EXP];
  endfunction

  function automatic logic [31:0] pack_levels(
    input logic [`UFS_CNT_W-1:0] rx_cnt,
    input logic [`UFS_CNT_W-1:0] tx_cnt
  );
    pack_levels = 32'h00000000;
    pack_levels[`UFS_LVL_RX_LSB +: `UFS_CNT_W] = rx_cnt;
    pack_levels[`UFS_LVL_TX_LSB +: `UFS_CNT_W] = tx_cnt;
  endfunction

  function automatic logic [31:0] pack_irq(input logic [`UFS_IRQ_W-1:0] bits);
    pack_irq = 32'h00000000;
    pack_irq[`UFS_IRQ_W-1:0] = bits;
  endfunction

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  wire ufs_pkg::ufs_sel_type sel;
  assign sel = (addr_i == `UFS_OFF_TSTAT) ? ufs_pkg::UFS_SEL_TSTAT :
               (addr_i == `UFS_OFF_LEVELS) ? ufs_pkg::UFS_SEL_LEVELS :
               (addr_i == `UFS_OFF_IRQ_STAT) ? ufs_pkg::UFS_SEL_IRQ_STAT :
               (addr_i == `UFS_OFF_IRQ_MASK) ? ufs_pkg::UFS_SEL_IRQ_MASK :
               ufs_pkg::UFS_SEL_NONE;

  // The timer status word shares its offset with the write-only control word:
  // a write there is a timer command, a read there is the status.
  wire wr_tctrl;
  wire rd_tstat;
  wire wr_irq_stat;
  wire wr_irq_mask;
  assign wr_tctrl = wr_i && (sel == ufs_pkg::UFS_SEL_TSTAT);
  assign rd_tstat = rd_i && (sel == ufs_pkg::UFS_SEL_TSTAT);
  assign wr_irq_stat = wr_i && (sel == ufs_pkg::UFS_SEL_IRQ_STAT);
  assign wr_irq_mask = wr_i && (sel == ufs_pkg::UFS_SEL_IRQ_MASK);

  // --------------------------------------------------------------------------
  // Timer control: gates and start commands
  // --------------------------------------------------------------------------
  logic gate_a_q;
  logic gate_b_q;
  logic gate_a_d;
  logic gate_b_d;
  logic start_a_q;
  logic start_b_q;
  wire start_a_d;
  wire start_b_d;

  assign gate_a_d = wr_tctrl ? wdata_i[`UFS_BIT_TA_GATE] : gate_a_q; // R06 R13
  assign gate_b_d = wr_tctrl ? wdata_i[`UFS_BIT_TB_GATE] : gate_b_q; // R06 R13
  // Start is a one-cycle pulse to the counter, which loads its count value.
  assign start_a_d = wr_tctrl && wdata_i[`UFS_BIT_TA_START]; // R12
  assign start_b_d = wr_tctrl && wdata_i[`UFS_BIT_TB_START]; // R12

  // Every control write rewrites both gates, so a start must carry the gates too.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gate_a_q <= `UFS_RST_GATE; // R13
      gate_b_q <= `UFS_RST_GATE; // R13
    end else begin
      gate_a_q <= gate_a_d;
      gate_b_q <= gate_b_d;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_a_q <= 1'b0;
      start_b_q <= 1'b0;
    end else begin
      start_a_q <= start_a_d;
      start_b_q <= start_b_d;
    end
  end

  // --------------------------------------------------------------------------
  // Timer expired flags
  // --------------------------------------------------------------------------
  wire [1:0] exp_set;
  wire [1:0] exp_clr;
  wire [1:0] exp_flag;

  assign exp_set[`UFS_BIT_TA_EXP] = timer_a_tc_i; // R05
  assign exp_set[`UFS_BIT_TB_EXP] = timer_b_tc_i; // R04
  // Only the expired flags are cleared by the read; gate bits are separate.
  assign exp_clr = {2{rd_tstat}}; // R02

  ufs_sticky_flag #(
    .WIDTH(2)
  ) u_exp_flags (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .set_i(exp_set),
    .clr_i(exp_clr),
    .flag_o(exp_flag)
  );

  // The indication is taken from the flags' next state so it falls in the
  // same cycle the read data appear, yet a pulse during the read keeps it.
  wire [1:0] exp_next;
  wire timer_irq_d;
  assign exp_next = exp_set | (exp_flag & ~exp_clr);
  assign timer_irq_d = |exp_next; // R01 R14

  // --------------------------------------------------------------------------
  // FIFO occupancy
  // --------------------------------------------------------------------------
  logic [`UFS_CNT_W-1:0] rx_cnt_q;
  logic [`UFS_CNT_W-1:0] tx_cnt_q;
  wire [`UFS_CNT_W-1:0] rx_cnt_d;
  wire [`UFS_CNT_W-1:0] tx_cnt_d;
  assign rx_cnt_d = clamp_count(rx_fifo_count_i); // R07
  assign tx_cnt_d = clamp_count(tx_fifo_count_i); // R08

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_cnt_q <= '0;
      tx_cnt_q <= '0;
    end else begin
      rx_cnt_q <= rx_cnt_d;
      tx_cnt_q <= tx_cnt_d;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status and mask
  // --------------------------------------------------------------------------
  // Events: each timer expiry, receive FIFO reaching full and transmit FIFO
  // draining to empty. Level events fire only on the change, so software can
  // clear them without them coming straight back.
  wire rx_full_evt;
  wire tx_empty_evt;
  assign rx_full_evt = (rx_cnt_d == DEPTH_C) && (rx_cnt_q != DEPTH_C);
  assign tx_empty_evt = (tx_cnt_d == '0) && (tx_cnt_q != '0);

  wire [`UFS_IRQ_W-1:0] irq_set;
  wire [`UFS_IRQ_W-1:0] irq_clr;
  wire [`UFS_IRQ_W-1:0] irq_stat;
  assign irq_set[`UFS_IRQ_TA] = timer_a_tc_i; // R05
  assign irq_set[`UFS_IRQ_TB] = timer_b_tc_i; // R04
  assign irq_set[`UFS_IRQ_RX_FULL] = rx_full_evt;
  assign irq_set[`UFS_IRQ_TX_EMPTY] = tx_empty_evt;
  assign irq_clr = wr_irq_stat ? wdata_i[`UFS_IRQ_W-1:0] : '0;

  ufs_sticky_flag #(
    .WIDTH(`UFS_IRQ_W)
  ) u_irq_stat (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .set_i(irq_set),
    .clr_i(irq_clr),
    .flag_o(irq_stat)
  );

  logic [`UFS_IRQ_W-1:0] irq_mask_q;
  wire [`UFS_IRQ_W-1:0] irq_mask_d;
  assign irq_mask_d = wr_irq_mask ? wdata_i[`UFS_IRQ_W-1:0] : irq_mask_q;

  wire [`UFS_IRQ_W-1:0] irq_stat_next;
  wire irq_d;
  assign irq_stat_next = irq_set | (irq_stat & ~irq_clr);
  assign irq_d = |(irq_stat_next & irq_mask_d);

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_mask_q <= `UFS_RST_IRQ_MASK;
    end else begin
      irq_mask_q <= irq_mask_d;
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  // Gate bits sit beside the flags but feed no interrupt term above.
  wire [31:0] tstat_word;
  wire [31:0] levels_word;
  wire [31:0] irq_stat_word;
  wire [31:0] irq_mask_word;
  wire [31:0] rd_word;

  assign tstat_word = pack_tstat(gate_b_q, gate_a_q, exp_flag); // R03
  assign levels_word = pack_levels(rx_cnt_q, tx_cnt_q); // R07 R08
  assign irq_stat_word = pack_irq(irq_stat);
  assign irq_mask_word = pack_irq(irq_mask_q);

  // Unmapped offsets read as zero; read data stand for one cycle only.
  assign rd_word = !rd_i ? 32'h00000000 :
                   (sel == ufs_pkg::UFS_SEL_TSTAT) ? tstat_word :
                   (sel == ufs_pkg::UFS_SEL_LEVELS) ? levels_word :
                   (sel == ufs_pkg::UFS_SEL_IRQ_STAT) ? irq_stat_word :
                   (sel == ufs_pkg::UFS_SEL_IRQ_MASK) ? irq_mask_word :
                   32'h00000000;

  // --------------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------------
  logic [31:0] rdata_q;
  logic timer_irq_q;
  logic irq_q;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rd_word;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timer_irq_q <= 1'b0;
    end else begin
      timer_irq_q <= timer_irq_d; // R01 R14
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign rdata_o = rdata_q;
  assign global_timer_irq_o = timer_irq_q;
  assign irq_o = irq_q;
  assign timer_a_start_o = start_a_q;
  assign timer_b_start_o = start_b_q;
  assign timer_a_gate_o = gate_a_q;
  assign timer_b_gate_o = gate_b_q;

endmodule

// File: rtl/ufs_sticky_flag.sv
`include "ufs_defines.svh"

module ufs_sticky_flag #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Per-bit set and clear
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  // Flag state
  output logic [WIDTH-1:0] flag_o
);

  if (WIDTH < 1) begin : g_bad_width
    $error("ufs_sticky_flag: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] flag_q;
  logic [WIDTH-1:0] flag_d;

  // A set in the same cycle as a clear wins, so no event is lost.
  assign flag_d = set_i | (flag_q & ~clr_i);

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;

endmodule

// File: verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic tca = 1'b0;
  logic tcb = 1'b0;
  logic [2:0] rx_c = 3'h0;
  logic [2:0] tx_c = 3'h0;
  logic [31:0] rdata;
  logic start_a, start_b, ga, gb, gti, irq;
  logic rd_q = 1'b0;
  logic [31:0] expq[$];
  logic [31:0] seed = 32'h987A;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;

  ufs_status_regs #(.FIFO_DEPTH(4)) uut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .timer_a_tc_i(tca), .timer_b_tc_i(tcb),
    .timer_a_start_o(start_a), .timer_b_start_o(start_b), .timer_a_gate_o(ga),
    .timer_b_gate_o(gb), .rx_fifo_count_i(rx_c), .tx_fifo_count_i(tx_c),
    .global_timer_irq_o(gti), .irq_o(irq)
  );

  always #12.5 clk_sys_i = ~clk_sys_i;

  // --------------------------------------------------------------------------
  // Bus tasks and checking
  // --------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    expq.push_back(e);
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
  endtask

  task automatic pulse(input logic a, input logic b);
    @(posedge clk_sys_i);
    tca <= a;
    tcb <= b;
    @(posedge clk_sys_i);
    tca <= 1'b0;
    tcb <= 1'b0;
    #1;
  endtask

  task automatic wrap_up;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // Read data are only valid in the cycle after the strobe, so compare there.
  always @(posedge clk_sys_i) begin
    if (rd_q) begin
      chk("rdata", expq.pop_front(), rdata);
    end
    rd_q <= rd_i;
  end

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      wrap_up();
    end
  end

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  initial begin
    logic [2:0] r;
    logic [2:0] t;
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rd(8'h0C, 32'h30);
    rd(8'h10, 32'h0);
    $display("test reset done");
    pulse(1'b1, 1'b0);
    chk("timer irq", 1, gti);
    rd(8'h0C, 32'h31);
    #1 chk("timer irq", 0, gti);
    rd(8'h0C, 32'h30);
    pulse(1'b0, 1'b1);
    rd(8'h0C, 32'h32);
    pulse(1'b1, 1'b1);
    rd(8'h0C, 32'h33);
    // An expiry landing on the clearing read must survive it.
    @(posedge clk_sys_i);
    tca <= 1'b1;
    addr_i <= 8'h0C;
    rd_i <= 1'b1;
    expq.push_back(32'h30);
    @(posedge clk_sys_i);
    tca <= 1'b0;
    rd_i <= 1'b0;
    #1 chk("timer irq", 1, gti);
    rd(8'h0C, 32'h31);
    $display("test expiry done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h0C, {26'h0, i[1:0], 2'h0, i[1:0]});
      #1 chk("starts", i[1:0], {start_b, start_a});
      chk("gates", i[1:0], {gb, ga});
      rd(8'h0C, {26'h0, i[1:0], 4'h0});
      #1 chk("timer irq", 0, gti);
    end
    $display("test gates done");
    wr(8'h10, 32'h77);
    rd(8'h10, 32'h0);
    rd(8'h40, 32'h0);
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      r = (i == 0) ? 3'h4 : 3'(seed[7:0] % 5);
      t = (i == 1) ? 3'h4 : 3'(seed[15:8] % 5);
      @(posedge clk_sys_i);
      rx_c <= r;
      tx_c <= t;
      rd(8'h10, {25'h0, r, 1'b0, t});
    end
    $display("test levels done");
    // Walk both FIFOs across their event edges once old events are cleared.
    @(posedge clk_sys_i);
    rx_c <= 3'h0;
    tx_c <= 3'h3;
    wr(8'h20, 32'hF);
    @(posedge clk_sys_i);
    rx_c <= 3'h4;
    tx_c <= 3'h0;
    rd(8'h20, 32'hC);
    wr(8'h20, 32'hF);
    wr(8'h24, 32'h1);
    pulse(1'b1, 1'b0);
    chk("irq", 1, irq);
    wr(8'h20, 32'h1);
    #1 chk("irq", 0, irq);
    rd(8'h0C, 32'h31);
    wr(8'h24, 32'h0);
    pulse(1'b1, 1'b0);
    chk("irq", 0, irq);
    rd(8'h20, 32'h1);
    rd(8'h0C, 32'h31);
    $display("test interrupts done");
    repeat (3) @(posedge clk_sys_i);
    wrap_up();
  end
endmodule

// File: verification/ufs_status_props.sv
module ufs_status_props #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // Timer side and levels
  input wire logic timer_a_tc_i,
  input wire logic timer_b_tc_i,
  input wire logic timer_a_start_o,
  input wire logic timer_b_start_o,
  input wire logic timer_a_gate_o,
  input wire logic timer_b_gate_o,
  input wire logic [2:0] rx_fifo_count_i,
  input wire logic [2:0] tx_fifo_count_i,
  input wire logic global_timer_irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  wire rd_st = rd_i && addr_i == 8'h0C;
  wire wr_ct = wr_i && addr_i == 8'h0C;
  wire tc_any = timer_a_tc_i || timer_b_tc_i;
  a_tca_sets_irq: assert property (timer_a_tc_i |=> global_timer_irq_o)
    else $error("timer A expiry not flagged");
  a_tcb_sets_irq: assert property (timer_b_tc_i |=> global_timer_irq_o)
    else $error("timer B expiry not flagged");
  a_read_clears: assert property (rd_st && !tc_any |=> !global_timer_irq_o)
    else $error("status read left timer irq set");
  a_irq_holds: assert property (global_timer_irq_o && !rd_st |=> global_timer_irq_o)
    else $error("timer irq dropped without read");
  a_irq_cause: assert property (!global_timer_irq_o && !tc_any |=> !global_timer_irq_o)
    else $error("timer irq rose without expiry");
  a_gate_mirror: assert property (wr_ct |=>
    {timer_b_gate_o, timer_a_gate_o} == $past(wdata_i[5:4]))
    else $error("gate outputs do not follow write");
  a_start_pulse: assert property (wr_ct |=>
    {timer_b_start_o, timer_a_start_o} == $past(wdata_i[1:0]))
    else $error("start pulse does not follow write");
  a_start_idle: assert property (!wr_ct |=> !timer_a_start_o && !timer_b_start_o)
    else $error("start pulse without write");
  a_status_bits: assert property (rd_st |=>
    rdata_o[31:2] == {26'h0, timer_b_gate_o, timer_a_gate_o, 2'h0})
    else $error("timer status gate or reserved bits wrong");
  a_level_read: assert property (rd_i && addr_i == 8'h10 &&
    $stable(rx_fifo_count_i) && $stable(tx_fifo_count_i)
    |=> rdata_o == {25'h0, $past(rx_fifo_count_i), 1'b0, $past(tx_fifo_count_i)})
    else $error("fifo level read wrong");
  c_tc_read: cover property (timer_a_tc_i ##[1:20] rd_st);
  c_gate_off: cover property (wr_ct && !wdata_i[4]);
  c_rx_full: cover property (rd_i && addr_i == 8'h10 && rx_fifo_count_i == 3'h4);
endmodule

bind ufs_status_regs ufs_status_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer_a_tc_i(timer_a_tc_i),
  .timer_b_tc_i(timer_b_tc_i), .timer_a_start_o(timer_a_start_o),
  .timer_b_start_o(timer_b_start_o), .timer_a_gate_o(timer_a_gate_o),
  .timer_b_gate_o(timer_b_gate_o), .rx_fifo_count_i(rx_fifo_count_i),
  .tx_fifo_count_i(tx_fifo_count_i), .global_timer_irq_o(global_timer_irq_o)
);
